/* shared/aopwc_regs.svh */
// Register map, field positions and reset values of the always-on
// power and wake control block. Included by the block's package users.
`ifndef AOPWC_REGS_SVH
`define AOPWC_REGS_SVH

// Byte addresses of the 32-bit APB words
`define AOPWC_CTRL_OFS 8'h00
`define AOPWC_STAT_OFS 8'h04
`define AOPWC_WEN_OFS 8'h08

// Control word fields
`define AOPWC_CTRL_REG_SD 1
`define AOPWC_CTRL_REF_SD 2
`define AOPWC_CTRL_DIR 3
`define AOPWC_CTRL_DRV 4
`define AOPWC_CTRL_W 16
`define AOPWC_CTRL_RST 16'h0010

// Status word fields
`define AOPWC_STAT_PIN 0
`define AOPWC_STAT_REG_ON 1
`define AOPWC_STAT_REF_ON 2
`define AOPWC_STAT_EXT_FL 5

// Wake source enable fields
`define AOPWC_WEN_ALARM 0
`define AOPWC_WEN_PERIODIC 1

// Cycles after reset before wake pin edges count
`define AOPWC_ARM_CYCLES 2'h3

`endif

/* shared/aopwc_pkg.sv */
// Types of the always-on power and wake control block.
// Assumes the register header is included by the design files.
`default_nettype none

package aopwc_pkg;

  // Power state of the regulators, reset comparator and bandgap
  typedef enum logic [1:0] {
    PWR_ON,
    PWR_REG_OFF,
    PWR_ALL_OFF
  } aopwc_pwr_t;

endpackage

`default_nettype wire

/* rtl/aopwc_sync.sv */
// Two-stage synchroniser for asynchronous levels.
// Assumes the destination clock is the block clock.
`timescale 1ns/1ps
`default_nettype none

module aopwc_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock
  input wire logic reset, // Async reset, active high
  input wire logic [W-1:0] d, // Asynchronous input
  output logic [W-1:0] q // Synchronised output
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // aopwc_sync

`default_nettype wire

/* rtl/aopwc_top.sv */
// Always-on power-down and wake pin control with an APB register port.
// Assumes alarm and periodic event pulses arrive on sys_clk; the wake
// pin is asynchronous and has an external pull-up.
//
// Overview of operation
// - Direction bit 3: 0 input, 1 output
// - Input wake pin: high level means wake
// - Output wake pin: open-drain, low only, pulled up
// - Bit 2 shuts regulators, comparator, bandgap
// - Leave full shutdown only on enabled wake
// - Bit 1 shuts regulators and reset comparator
// - Regulator-only shutdown keeps bandgap powered
// - Leave regulator shutdown on enabled wake, or for full shutdown via bit 2
// - Drive bit 4 resets 1; 0 pulls low
// - Pin assertion sets flag bit 5, W1C
`timescale 1ns/1ps
`default_nettype none
`include "aopwc_regs.svh"

module aopwc_top #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk, // Block clock, 25 MHz
  input wire logic reset, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, 1 write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte lane strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic wake_pin_i, // Wake pin level, asynchronous
  output logic wake_pin_o, // Wake pin drive value
  output logic wake_pin_oe, // Wake pin drive enable, high drives
  input wire logic alarm_evt, // Alarm event pulse
  input wire logic periodic_evt, // Periodic event pulse
  output logic regulator_en, // All on-chip regulators enable
  output logic reset_comparator_en, // Power-on reset comparator enable
  output logic bandgap_en // Bandgap reference enable
);

  initial begin
    if (ADDR_W < 4 || ADDR_W > 32) begin
      $error("aopwc_top: ADDR_W must lie between 4 and 32");
    end
  end

  // Wake pin synchroniser
  logic wake_sync;
  aopwc_sync #(.W(1)) u_wake_sync (
    .clk(sys_clk),
    .reset(reset),
    .d(wake_pin_i),
    .q(wake_sync)
  );

  // Register and state storage
  logic [`AOPWC_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [1:0] wen_r, wen_nxt;
  logic ext_flag_r, ext_flag_nxt;
  logic pin_prev_r, pin_prev_nxt;
  logic [1:0] arm_r, arm_nxt;
  aopwc_pkg::aopwc_pwr_t pwr_r, pwr_nxt;

  // Next values of the flops behind the outputs
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;
  logic wake_pin_o_nxt;
  logic wake_pin_oe_nxt;
  logic regulator_en_nxt;
  logic reset_comparator_en_nxt;
  logic bandgap_en_nxt;

  // Bus decode and read words
  logic bus_answer;
  logic bus_commit;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_wen;
  logic hit_any;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_wen;
  logic [31:0] stat_word;

  // Wake sources and pin edge detection
  logic pin_wake;
  logic alarm_wake;
  logic periodic_wake;
  logic wake_req;
  logic pin_armed;
  logic pin_rise;

  // Answer one cycle into the access phase, commit when pready is
  // seen; one wait state keeps every output a plain flop
  assign bus_answer = psel & penable & ~pready;
  assign bus_commit = psel & penable & pready;

  // Address decode on whole words
  assign hit_ctrl = (paddr == ADDR_W'(`AOPWC_CTRL_OFS));
  assign hit_stat = (paddr == ADDR_W'(`AOPWC_STAT_OFS));
  assign hit_wen = (paddr == ADDR_W'(`AOPWC_WEN_OFS));
  assign hit_any = hit_ctrl | hit_stat | hit_wen;

  // All fields sit in the low byte, so only its strobe matters
  assign wr_ctrl = bus_commit & pwrite & hit_ctrl & pstrb[0];
  assign wr_stat = bus_commit & pwrite & hit_stat & pstrb[0];
  assign wr_wen = bus_commit & pwrite & hit_wen & pstrb[0];

  // Pin wakes only while it is an input; a level, not an edge
  assign pin_wake = ~ctrl_r[`AOPWC_CTRL_DIR] & wake_sync;
  assign alarm_wake = alarm_evt & wen_r[`AOPWC_WEN_ALARM];
  assign periodic_wake = periodic_evt & wen_r[`AOPWC_WEN_PERIODIC];
  assign wake_req = pin_wake | alarm_wake | periodic_wake;

  // Edges are ignored until the synchroniser holds the true level,
  // so a pin idling high gives no false event after reset
  assign pin_armed = (arm_r == `AOPWC_ARM_CYCLES);
  assign pin_rise = pin_armed & pin_wake & ~pin_prev_r;

  // Status word as software reads it
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`AOPWC_STAT_PIN] = wake_sync;
    stat_word[`AOPWC_STAT_REG_ON] = regulator_en;
    stat_word[`AOPWC_STAT_REF_ON] = bandgap_en;
    stat_word[`AOPWC_STAT_EXT_FL] = ext_flag_r;
  end

  // Register writes, wake clearing and the event flag
  always_comb begin
    ctrl_nxt = ctrl_r;
    wen_nxt = wen_r;
    ext_flag_nxt = ext_flag_r;
    pin_prev_nxt = pin_wake;
    arm_nxt = pin_armed ? arm_r : arm_r + 2'h1;
    if (wr_ctrl) begin
      ctrl_nxt[`AOPWC_CTRL_DIR] = pwdata[`AOPWC_CTRL_DIR];
      ctrl_nxt[`AOPWC_CTRL_DRV] = pwdata[`AOPWC_CTRL_DRV];
      if (pwr_r == aopwc_pkg::PWR_ON) begin
        ctrl_nxt[`AOPWC_CTRL_REG_SD] = pwdata[`AOPWC_CTRL_REG_SD];
        ctrl_nxt[`AOPWC_CTRL_REF_SD] = pwdata[`AOPWC_CTRL_REF_SD];
      end else begin
        // While shut down, software may only widen the shutdown
        ctrl_nxt[`AOPWC_CTRL_REG_SD] = ctrl_r[`AOPWC_CTRL_REG_SD] |
          pwdata[`AOPWC_CTRL_REG_SD];
        ctrl_nxt[`AOPWC_CTRL_REF_SD] = ctrl_r[`AOPWC_CTRL_REF_SD] |
          pwdata[`AOPWC_CTRL_REF_SD];
      end
    end
    if (wr_wen) begin
      wen_nxt = pwdata[1:0];
    end
    // A wake ends either shutdown and beats a write in the same cycle
    if (wake_req && pwr_r != aopwc_pkg::PWR_ON) begin
      ctrl_nxt[`AOPWC_CTRL_REG_SD] = 1'b0;
      ctrl_nxt[`AOPWC_CTRL_REF_SD] = 1'b0;
    end
    // Write one clears; a pin edge in the same cycle wins
    if (wr_stat && pwdata[`AOPWC_STAT_EXT_FL]) begin
      ext_flag_nxt = 1'b0;
    end
    if (pin_rise) begin
      ext_flag_nxt = 1'b1;
    end
  end

  // Power state; the full shutdown wins when both bits are set
  always_comb begin
    pwr_nxt = pwr_r;
    unique case (pwr_r)
      aopwc_pkg::PWR_ON: begin
        if (ctrl_nxt[`AOPWC_CTRL_REF_SD]) begin
          pwr_nxt = aopwc_pkg::PWR_ALL_OFF;
        end else if (ctrl_nxt[`AOPWC_CTRL_REG_SD]) begin
          pwr_nxt = aopwc_pkg::PWR_REG_OFF;
        end
      end
      aopwc_pkg::PWR_REG_OFF: begin
        if (wake_req) begin
          pwr_nxt = aopwc_pkg::PWR_ON;
        end else if (ctrl_nxt[`AOPWC_CTRL_REF_SD]) begin
          pwr_nxt = aopwc_pkg::PWR_ALL_OFF;
        end
      end
      aopwc_pkg::PWR_ALL_OFF: begin
        if (wake_req) begin
          pwr_nxt = aopwc_pkg::PWR_ON;
        end
      end
      default: begin
        // Unused code: fall back to what the control bits ask for
        if (ctrl_nxt[`AOPWC_CTRL_REF_SD]) begin
          pwr_nxt = aopwc_pkg::PWR_ALL_OFF;
        end else if (ctrl_nxt[`AOPWC_CTRL_REG_SD]) begin
          pwr_nxt = aopwc_pkg::PWR_REG_OFF;
        end else begin
          pwr_nxt = aopwc_pkg::PWR_ON;
        end
      end
    endcase
  end

  // Enables and pin drive follow the next state, so the output
  // flops change on the same edge as the state they report
  always_comb begin
    regulator_en_nxt = (pwr_nxt == aopwc_pkg::PWR_ON);
    reset_comparator_en_nxt = (pwr_nxt == aopwc_pkg::PWR_ON);
    bandgap_en_nxt = (pwr_nxt != aopwc_pkg::PWR_ALL_OFF);
    wake_pin_oe_nxt = ctrl_nxt[`AOPWC_CTRL_DIR] &
      ~ctrl_nxt[`AOPWC_CTRL_DRV];
    wake_pin_o_nxt = ctrl_nxt[`AOPWC_CTRL_DRV];
  end

  // Bus answer; read data is taken in the first access-phase cycle and shown only while pready is high
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pready_nxt = bus_answer;
    pslverr_nxt = 1'b0;
    if (bus_answer) begin
      pslverr_nxt = ~hit_any;
      if (!pwrite && hit_ctrl) begin
        prdata_nxt = {16'h0000, ctrl_r};
      end else if (!pwrite && hit_stat) begin
        prdata_nxt = stat_word;
      end else if (!pwrite && hit_wen) begin
        prdata_nxt = {30'h0, wen_r};
      end
    end
  end

  // State flops; reset loads constants only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `AOPWC_CTRL_RST;
      wen_r <= 2'h0;
      ext_flag_r <= 1'b0;
      pin_prev_r <= 1'b0;
      arm_r <= 2'h0;
      pwr_r <= aopwc_pkg::PWR_ON;
    end else begin
      ctrl_r <= ctrl_nxt;
      wen_r <= wen_nxt;
      ext_flag_r <= ext_flag_nxt;
      pin_prev_r <= pin_prev_nxt;
      arm_r <= arm_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  // Output flops; everything starts powered and the pin released
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      wake_pin_o <= 1'b1;
      wake_pin_oe <= 1'b0;
      regulator_en <= 1'b1;
      reset_comparator_en <= 1'b1;
      bandgap_en <= 1'b1;
    end else begin
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      wake_pin_o <= wake_pin_o_nxt;
      wake_pin_oe <= wake_pin_oe_nxt;
      regulator_en <= regulator_en_nxt;
      reset_comparator_en <= reset_comparator_en_nxt;
      bandgap_en <= bandgap_en_nxt;
    end
  end

  // Assertions share the block clock and are off during reset
  default clocking chk_clk @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  chk_bandgap_off: assert property (
    bandgap_en == (pwr_r != aopwc_pkg::PWR_ALL_OFF)
  ) else $error("bandgap enable disagrees with power state");

  chk_regulator_off: assert property (
    (regulator_en == (pwr_r == aopwc_pkg::PWR_ON)) &&
    (reset_comparator_en == regulator_en)
  ) else $error("regulator enables disagree with power state");

  chk_full_wins: assert property (
    ctrl_r[`AOPWC_CTRL_REF_SD] |-> pwr_r == aopwc_pkg::PWR_ALL_OFF
  ) else $error("reference shutdown set but bandgap kept");

  chk_no_self_wake: assert property (
    (pwr_r != aopwc_pkg::PWR_ON) && !wake_req |=>
    pwr_r != aopwc_pkg::PWR_ON
  ) else $error("shutdown left without a wake source");

  chk_drive_low_only: assert property (
    wake_pin_oe |-> !wake_pin_o
  ) else $error("wake pin driven high");

  chk_drive_when_output: assert property (
    wake_pin_oe == (ctrl_r[`AOPWC_CTRL_DIR] && !ctrl_r[`AOPWC_CTRL_DRV])
  ) else $error("wake pin drive enable disagrees with control");

  chk_flag_on_rise: assert property (
    pin_rise |=> ext_flag_r
  ) else $error("pin assertion did not set the event flag");

  // Main scenarios worth seeing once
  cov_reg_wake: cover property (
    pwr_r == aopwc_pkg::PWR_REG_OFF ##1 pwr_r == aopwc_pkg::PWR_ON
  );
  cov_full_wake: cover property (
    pwr_r == aopwc_pkg::PWR_ALL_OFF ##1 pwr_r == aopwc_pkg::PWR_ON
  );
  cov_flag_set: cover property (!ext_flag_r ##1 ext_flag_r);
  cov_bus_error: cover property (pready && pslverr);

endmodule // aopwc_top

`default_nettype wire

/* testbench/aopwc_pin_model.sv */
// Wake pin far side: pull-up plus an outside low driver.
// Assumes the design drives the pin only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
module aopwc_pin_model (
  input wire logic wake_pin_o, // Design drive value
  input wire logic wake_pin_oe, // Design drive enable
  input wire logic ext_low, // Outside party holds pin low
  output logic wake_pin_i // Resolved pin level
);
  // Pull-up wins whenever nobody pulls low
  assign wake_pin_i = ~((wake_pin_oe & ~wake_pin_o) | ext_low);
endmodule // aopwc_pin_model
`default_nettype wire

/* testbench/test_always_on_power_wake_control.sv */
// Bench for the power and wake control block.
// Assumes the pin model stands on the wake pin.
`timescale 1ns/1ps
`default_nettype none
module test_always_on_power_wake_control;
  logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic alarm_evt = 0, periodic_evt = 0, ext_low = 1, wake_pin_i, pready;
  logic pslverr, wake_pin_o, wake_pin_oe, regulator_en, reset_comparator_en;
  logic bandgap_en;
  logic [7:0] paddr = 0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [31:0] rows [3] = '{32'h12, 32'h14, 32'h16};
  logic [2:0] exps [3] = '{3'h1, 3'h0, 3'h0};
  int n_mismatch = 0, total_checks = 0;
  initial forever #20 sys_clk = ~sys_clk;
  aopwc_top u_aopwc_top (.*);
  aopwc_pin_model u_aopwc_pin_model (.*);
  task automatic end_of_test;
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Holds the request until pready, bounded so a hang ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++i < 50);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (i == 50) begin
      chk(0, 1);
      end_of_test;
    end
    @(posedge sys_clk);
  endtask
  // The wake pin goes through a synchroniser, so poll with a bound
  task automatic wt(input logic [2:0] e);
    logic [2:0] g;
    for (int i = 0; i < 50; i++) begin
      g = {regulator_en, reset_comparator_en, bandgap_en};
      if (g !== e) @(posedge sys_clk);
    end
    chk({29'h0, g}, {29'h0, e});
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 0;
    @(posedge sys_clk);
    apb(0, 8'h00, 0);
    chk(rd, 32'h10);
    apb(0, 8'hfc, 0);
    chk({31'h0, err}, 1);
    for (int k = 0; k < 3; k++) begin
      apb(1, 8'h00, rows[k]);
      wt(exps[k]);
      ext_low <= 0;
      wt(3'h7);
      ext_low <= 1;
      apb(1, 8'h00, 32'h10);
    end
    apb(0, 8'h04, 0);
    chk(rd & 32'h20, 32'h20);
    apb(1, 8'h04, 32'h20);
    apb(0, 8'h04, 0);
    chk(rd & 32'h20, 0);
    apb(1, 8'h08, 32'h1);
    apb(1, 8'h00, 32'h14);
    wt(3'h0);
    alarm_evt <= 1;
    @(posedge sys_clk) alarm_evt <= 0;
    wt(3'h7);
    apb(1, 8'h08, 32'h2);
    apb(1, 8'h00, 32'h12);
    alarm_evt <= 1;
    @(posedge sys_clk) alarm_evt <= 0;
    repeat (4) @(posedge sys_clk);
    wt(3'h1);
    periodic_evt <= 1;
    @(posedge sys_clk) periodic_evt <= 0;
    wt(3'h7);
    apb(1, 8'h00, 32'h1a);
    ext_low <= 0;
    repeat (8) @(posedge sys_clk);
    wt(3'h1);
    ext_low <= 0;
    apb(1, 8'h00, 32'h08);
    chk({31'h0, wake_pin_i}, 0);
    end_of_test;
  end
endmodule // test_always_on_power_wake_control
`default_nettype wire
